// ---- hdl/tseg_pkg.sv ----
// tseg_pkg: register map, field positions and reset values of the timer
// software event block.
// assumes: a 32-bit AHB-Lite bus with word-aligned registers.
package tseg_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;  // control
  localparam logic [7:0] IRQ_EN_OFS  = 8'h0c;  // interrupt mask
  localparam logic [7:0] STATUS_OFS  = 8'h10;  // sticky event status
  localparam logic [7:0] EVTRIG_OFS  = 8'h14;  // event_trigger
  localparam logic [7:0] CHMODE_OFS  = 8'h18;  // channel_mode_1
  localparam logic [7:0] CHEN_OFS    = 8'h20;  // channel enable
  localparam logic [7:0] COUNT_OFS   = 8'h24;  // counter value, read only
  localparam logic [7:0] PSC_OFS     = 8'h28;  // prescaler factor
  localparam logic [7:0] RELOAD_OFS  = 8'h2c;  // auto_reload_value
  localparam logic [7:0] CH1VAL_OFS  = 8'h34;  // ch1 compare / capture value

  // ************************************************************
  // field positions
  // ************************************************************
  // event_trigger and status share bit positions
  localparam int UPD_BIT      = 0;
  localparam int CH1_BIT      = 1;
  localparam int CTRLUPD_BIT  = 5;
  localparam int BRK_BIT      = 7;
  localparam int OVCAP_BIT    = 9;
  localparam int STATUS_W     = 10;
  // control register
  localparam int CNT_EN_BIT   = 0;
  localparam int UPD_DIS_BIT  = 1;
  localparam int UPD_SRC_BIT  = 2;
  localparam int DOWN_BIT     = 4;
  localparam int CENTER_LO    = 5;
  localparam int CENTER_HI    = 6;
  localparam int DMA_EN_BIT   = 8;
  localparam int CTRL_W       = 9;
  // channel_mode_1
  localparam int DIR_LO       = 0;
  localparam int DIR_HI       = 1;
  localparam int PRELOAD_BIT  = 3;
  localparam int REG_W        = 16;

  // ************************************************************
  // reset values and encodings
  // ************************************************************
  localparam logic [REG_W-1:0]    REG_RST    = 16'h0000;
  localparam logic [STATUS_W-1:0] STATUS_RST = 10'h000;
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 9'h000;
  localparam logic [1:0]          DIR_OUTPUT = 2'h0;  // 01,10,11 are inputs
  localparam logic [31:0]         READ_ZERO  = 32'h0000_0000;

  // read access position in the two-cycle read
  typedef enum logic [0:0] {
    TSEG_IDLE,
    TSEG_READ
  } tseg_bus_type;

endpackage : tseg_pkg

// ---- hdl/tseg_core.sv ----
// tseg_core: prescaler and main counter of the timer.
// assumes: reinit is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module tseg_core (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // configuration
  input  wire logic        run,
  input  wire logic        count_down,
  input  wire logic        center,
  input  wire logic [15:0] psc_factor,
  input  wire logic [15:0] reload,
  // software forced re-initialisation
  input  wire logic        reinit,
  // state
  output logic      [15:0] count,
  output logic             wrap
);

  logic [15:0] psc_reg;
  logic        up_phase_reg;

  // ************************************************************
  // prescaler and counter
  // ************************************************************
  // reinit clears the prescaler count and restarts the counter (reload when counting down edge-aligned, else zero); the factor stays as programmed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_reg      <= 16'h0000;
      count        <= 16'h0000;
      up_phase_reg <= 1'b1;
      wrap         <= 1'b0;
    end else if (reinit) begin
      psc_reg      <= 16'h0000;
      count        <= (count_down && !center) ? reload : 16'h0000;
      up_phase_reg <= 1'b1;
      wrap         <= 1'b0;
    end else if (run && psc_reg == psc_factor) begin
      psc_reg <= 16'h0000;
      wrap    <= 1'b0;
      if (center) begin
        if (up_phase_reg && count >= reload) begin
          up_phase_reg <= 1'b0;
          count        <= count - 16'h0001;
          wrap         <= 1'b1;
        end else if (!up_phase_reg && count == 16'h0000) begin
          up_phase_reg <= 1'b1;
          count        <= count + 16'h0001;
          wrap         <= 1'b1;
        end else begin
          count <= up_phase_reg ? count + 16'h0001 : count - 16'h0001;
        end
      end else if (count_down) begin
        count <= (count == 16'h0000) ? reload : count - 16'h0001;
        wrap  <= (count == 16'h0000);
      end else begin
        count <= (count >= reload) ? 16'h0000 : count + 16'h0001;
        wrap  <= (count >= reload);
      end
    end else begin
      psc_reg <= run ? psc_reg + 16'h0001 : psc_reg;
      wrap    <= 1'b0;
    end
  end

endmodule : tseg_core

// ---- hdl/tseg_top.sv ----
// tseg_top: software event generation of a timer, with its counter,
// channel 1 capture/compare and an AHB-Lite register slave.
// assumes: one clock hclk, one AHB-Lite master, this slave alone on hready.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module tseg_top #(
  parameter bit HAS_COMPLEMENT = 1'b1  // channel has complementary outputs
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // event strobes to the rest of the timer
  output logic             update_event,
  output logic             ch1_capture_event,
  output logic             ctrl_update_event,
  output logic             break_event,
  output logic             ch1_dma_req,
  // interrupt
  output logic             irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  tseg_pkg::tseg_bus_type        bus_reg;
  logic                          wr_pend_reg;
  logic [7:0]                    wr_addr_reg;
  logic [7:0]                    rd_addr_reg;
  logic                          addr_take;
  logic                          wr_now;
  logic [tseg_pkg::CTRL_W-1:0]   ctrl_reg;
  logic [tseg_pkg::STATUS_W-1:0] irq_en_reg;
  logic [tseg_pkg::STATUS_W-1:0] status_reg;
  logic [tseg_pkg::STATUS_W-1:0] status_set;
  logic [tseg_pkg::REG_W-1:0]    chmode_reg;
  logic                          ch1_enable_reg;
  logic [tseg_pkg::REG_W-1:0]    psc_reg;
  logic [tseg_pkg::REG_W-1:0]    reload_reg;
  logic [tseg_pkg::REG_W-1:0]    ch1_val_reg;
  logic [tseg_pkg::REG_W-1:0]    ch1_shadow_reg;
  logic                          upd_trig_reg;
  logic                          ch1_trig_reg;
  logic                          ctrl_trig_reg;
  logic                          brk_trig_reg;
  logic                          is_output;
  logic                          upd_fire;
  logic                          ch1_match;
  logic                          match_prev_reg;
  logic                          ch1_fire;
  logic [15:0]                   count;
  logic                          wrap;
  logic [31:0]                   rd_mux;

  // ************************************************************
  // bus decode
  // ************************************************************
  // a transfer is taken in its address phase; writes land one cycle later
  // writes run with no wait state, reads insert exactly one; hresp never
  // signals an error, unmapped or unaligned words simply read as zero
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_now    = wr_pend_reg;

  // address phase capture and read wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg     <= tseg_pkg::TSEG_IDLE;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      unique case (bus_reg)
        tseg_pkg::TSEG_IDLE: begin
          if (addr_take && !hwrite) begin
            bus_reg   <= tseg_pkg::TSEG_READ;
            hreadyout <= 1'b0;                  // one wait state per read
          end
        end
        tseg_pkg::TSEG_READ: begin
          bus_reg   <= tseg_pkg::TSEG_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
      if (addr_take) begin
        wr_addr_reg <= haddr[7:0];
        rd_addr_reg <= haddr[7:0];
      end
    end
  end

  // read data mux; unmapped addresses read zero
  always_comb begin
    rd_mux = tseg_pkg::READ_ZERO;
    if (rd_addr_reg[1:0] == 2'h0) begin
      unique case (rd_addr_reg)
        tseg_pkg::CTRL_OFS:   rd_mux = {23'h000000, ctrl_reg};
        tseg_pkg::IRQ_EN_OFS: rd_mux = {22'h000000, irq_en_reg};
        tseg_pkg::STATUS_OFS: rd_mux = {22'h000000, status_reg};
        tseg_pkg::EVTRIG_OFS: rd_mux = tseg_pkg::READ_ZERO;
        tseg_pkg::CHMODE_OFS: rd_mux = {16'h0000, chmode_reg};
        tseg_pkg::CHEN_OFS:   rd_mux = {31'h00000000, ch1_enable_reg};
        tseg_pkg::COUNT_OFS:  rd_mux = {16'h0000, count};
        tseg_pkg::PSC_OFS:    rd_mux = {16'h0000, psc_reg};
        tseg_pkg::RELOAD_OFS: rd_mux = {16'h0000, reload_reg};
        tseg_pkg::CH1VAL_OFS: rd_mux = {16'h0000, ch1_val_reg};
        default:              rd_mux = tseg_pkg::READ_ZERO;
      endcase
    end
  end

  // read data register, loaded in the wait cycle; response always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= tseg_pkg::READ_ZERO;
      hresp  <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_reg == tseg_pkg::TSEG_READ) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  // control, mask, enable, prescaler and reload words
  // status and trigger words are not in this list: writes to them drop here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg       <= tseg_pkg::CTRL_RST;
      irq_en_reg     <= tseg_pkg::STATUS_RST;
      ch1_enable_reg <= 1'b0;
      psc_reg        <= tseg_pkg::REG_RST;
      reload_reg     <= tseg_pkg::REG_RST;
    end else if (wr_now) begin
      unique case (wr_addr_reg)
        tseg_pkg::CTRL_OFS:   ctrl_reg       <= hwdata[tseg_pkg::CTRL_W-1:0];
        tseg_pkg::IRQ_EN_OFS: irq_en_reg     <= hwdata[tseg_pkg::STATUS_W-1:0];
        tseg_pkg::CHEN_OFS:   ch1_enable_reg <= hwdata[0];
        tseg_pkg::PSC_OFS:    psc_reg        <= hwdata[tseg_pkg::REG_W-1:0];
        tseg_pkg::RELOAD_OFS: reload_reg     <= hwdata[tseg_pkg::REG_W-1:0];
        default: ;
      endcase
    end
  end

  // channel mode: direction locked while channel enabled
  // bits above the direction field are stored whatever the direction;
  // their meaning follows the direction code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chmode_reg <= tseg_pkg::REG_RST;
    end else if (wr_now && wr_addr_reg == tseg_pkg::CHMODE_OFS) begin
      chmode_reg[tseg_pkg::REG_W-1:tseg_pkg::DIR_HI+1] <=
        hwdata[tseg_pkg::REG_W-1:tseg_pkg::DIR_HI+1];
      if (!ch1_enable_reg) begin
        chmode_reg[tseg_pkg::DIR_HI:tseg_pkg::DIR_LO] <=
          hwdata[tseg_pkg::DIR_HI:tseg_pkg::DIR_LO];
      end
    end
  end

  // direction decode: 00 compare output, any other code a capture input
  assign is_output = chmode_reg[tseg_pkg::DIR_HI:tseg_pkg::DIR_LO]
                     == tseg_pkg::DIR_OUTPUT;

  // ************************************************************
  // self-clearing trigger bits
  // ************************************************************
  // each trigger holds for one cycle only, so nothing reads back
  // the triggers load at the end of the write data phase and their effects
  // (counter reload, flags) land one clock later, so software reading the
  // result must leave one idle cycle after the write
  // reserved bits 4:2, 6 and 15:8 are never looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_trig_reg  <= 1'b0;
      ch1_trig_reg  <= 1'b0;
      ctrl_trig_reg <= 1'b0;
      brk_trig_reg  <= 1'b0;
    end else begin
      upd_trig_reg  <= 1'b0;
      ch1_trig_reg  <= 1'b0;
      ctrl_trig_reg <= 1'b0;
      brk_trig_reg  <= 1'b0;
      if (wr_now && wr_addr_reg == tseg_pkg::EVTRIG_OFS) begin
        upd_trig_reg  <= hwdata[tseg_pkg::UPD_BIT];
        ch1_trig_reg  <= hwdata[tseg_pkg::CH1_BIT];
        ctrl_trig_reg <= hwdata[tseg_pkg::CTRLUPD_BIT] && HAS_COMPLEMENT;
        brk_trig_reg  <= hwdata[tseg_pkg::BRK_BIT];
      end
    end
  end

  // forced update is blocked by update_disable
  assign upd_fire = upd_trig_reg && !ctrl_reg[tseg_pkg::UPD_DIS_BIT];

  // ************************************************************
  // counter and prescaler
  // ************************************************************
  tseg_core u_core (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .run        (ctrl_reg[tseg_pkg::CNT_EN_BIT]),
    .count_down (ctrl_reg[tseg_pkg::DOWN_BIT]),
    .center     (|ctrl_reg[tseg_pkg::CENTER_HI:tseg_pkg::CENTER_LO]),
    .psc_factor (psc_reg),
    .reload     (reload_reg),
    .reinit     (upd_fire),
    .count      (count),
    .wrap       (wrap)
  );

  // ************************************************************
  // channel 1 compare and capture
  // ************************************************************
  // compare match is edge-detected so a held count fires once
  // out of reset count and compare value are both zero, so the match is
  // already true; the history starts high so that this is not taken for
  // a fresh match in the first cycle after reset
  assign ch1_match = is_output && count == ch1_val_reg;
  assign ch1_fire  = ch1_trig_reg || (ch1_match && !match_prev_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_prev_reg <= 1'b1;
    end else begin
      match_prev_reg <= ch1_match;
    end
  end

  // compare value with preload in output mode, counter capture in input mode
  // an input-mode trigger captures the counter ahead of any software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch1_val_reg    <= tseg_pkg::REG_RST;
      ch1_shadow_reg <= tseg_pkg::REG_RST;
    end else begin
      if (ch1_trig_reg && !is_output) begin
        ch1_val_reg <= count;
      end else if (wr_now && wr_addr_reg == tseg_pkg::CH1VAL_OFS && is_output) begin
        ch1_shadow_reg <= hwdata[tseg_pkg::REG_W-1:0];
        if (!chmode_reg[tseg_pkg::PRELOAD_BIT]) begin
          ch1_val_reg <= hwdata[tseg_pkg::REG_W-1:0];
        end
      end else if ((upd_fire || wrap) && chmode_reg[tseg_pkg::PRELOAD_BIT]
                   && is_output) begin
        ch1_val_reg <= ch1_shadow_reg;
      end
    end
  end

  // ************************************************************
  // status flags and interrupt
  // ************************************************************
  // hardware set sources, one bit per event
  always_comb begin
    status_set = tseg_pkg::STATUS_RST;
    status_set[tseg_pkg::UPD_BIT] = (upd_fire && !ctrl_reg[tseg_pkg::UPD_SRC_BIT])
                                    || (wrap && !ctrl_reg[tseg_pkg::UPD_DIS_BIT]);
    status_set[tseg_pkg::CH1_BIT]     = ch1_fire;
    status_set[tseg_pkg::CTRLUPD_BIT] = ctrl_trig_reg;
    status_set[tseg_pkg::BRK_BIT]     = brk_trig_reg;
    status_set[tseg_pkg::OVCAP_BIT]   = ch1_trig_reg && !is_output
                                        && status_reg[tseg_pkg::CH1_BIT];
  end

  // sticky flags, cleared by a status read; a set in that cycle wins
  // the clear happens in the read's wait cycle, the cycle in which the old
  // value is copied to hrdata, so no flag is lost between the two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= tseg_pkg::STATUS_RST;
    end else if (bus_reg == tseg_pkg::TSEG_READ && rd_addr_reg == tseg_pkg::STATUS_OFS) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  // level interrupt from unmasked flags
  // registered, so irq follows the flags one clock later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & irq_en_reg);
    end
  end

  // ************************************************************
  // event strobes
  // ************************************************************
  // one-cycle strobes to the channel, output and break logic
  // each strobe follows its trigger or source by one clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_event      <= 1'b0;
      ch1_capture_event <= 1'b0;
      ctrl_update_event <= 1'b0;
      break_event       <= 1'b0;
      ch1_dma_req       <= 1'b0;
    end else begin
      update_event      <= upd_fire || (wrap && !ctrl_reg[tseg_pkg::UPD_DIS_BIT]);
      ch1_capture_event <= ch1_fire;
      ctrl_update_event <= ctrl_trig_reg;
      break_event       <= brk_trig_reg;
      ch1_dma_req       <= ch1_fire && ctrl_reg[tseg_pkg::DMA_EN_BIT];
    end
  end

endmodule : tseg_top

// ---- test/tseg_top_chk.sv ----
// tseg_top_chk: concurrent checks on the ports of the timer event block.
// assumes: bound into tseg_top, hready tied to hreadyout, one master.
`timescale 1ns/1ps
module tseg_top_chk #(
  parameter bit HAS_COMPLEMENT = 1'b1
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  // event strobes
  input wire logic        update_event,
  input wire logic        ch1_capture_event,
  input wire logic        ctrl_update_event,
  input wire logic        break_event,
  input wire logic        ch1_dma_req
);
  logic       wr_q;
  logic [7:0] adr_q;
  logic [7:0] trig_q;
  logic       upd_dis_q;
  logic       dma_en_q;
  logic       wr_dp;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign wr_dp = hready && wr_q;

  // ************************************************************
  // helper state
  // ************************************************************
  // address phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      adr_q <= 8'h00;
    end else if (hready) begin
      wr_q  <= hsel && htrans[1] && hwrite;
      adr_q <= haddr[7:0];
    end
  end
  // trigger bits seen in a write data phase, one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_q <= 8'h00;
    end else begin
      trig_q <= (wr_dp && adr_q == tseg_pkg::EVTRIG_OFS) ? hwdata[7:0] : 8'h00;
    end
  end
  // control bits written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_dis_q <= 1'b0;
      dma_en_q  <= 1'b0;
    end else if (wr_dp && adr_q == tseg_pkg::CTRL_OFS) begin
      upd_dis_q <= hwdata[tseg_pkg::UPD_DIS_BIT];
      dma_en_q  <= hwdata[tseg_pkg::DMA_EN_BIT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_UPD_FORCED: assert property (trig_q[0] && !upd_dis_q |=> update_event)
    else $error("forced update gave no update pulse");
  AST_CH1_FORCED: assert property (trig_q[1] |=> ch1_capture_event)
    else $error("forced channel event gave no pulse");
  AST_CTRL_FORCED: assert property (trig_q[5] |=> ctrl_update_event == HAS_COMPLEMENT)
    else $error("control update pulse wrong");
  AST_CTRL_CAUSE: assert property (ctrl_update_event |-> $past(trig_q[5]))
    else $error("control update pulse without trigger");
  AST_BRK_FORCED: assert property (trig_q[7] |=> break_event ##1 !break_event)
    else $error("forced break pulse wrong");
  AST_BRK_CAUSE: assert property (break_event |-> $past(trig_q[7]))
    else $error("break pulse without trigger");
  AST_DMA_GATE: assert property (ch1_dma_req |-> ch1_capture_event && dma_en_q)
    else $error("dma request without enabled channel event");
  AST_DMA_FORCED: assert property (trig_q[1] && dma_en_q |=> ch1_dma_req)
    else $error("forced channel event gave no dma request");
  AST_TRIG_READ: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[7:0] == tseg_pkg::EVTRIG_OFS |=> !hreadyout ##1 (hreadyout && hrdata == 32'h0))
    else $error("trigger register read not zero");
endmodule : tseg_top_chk

bind tseg_top tseg_top_chk #(.HAS_COMPLEMENT(HAS_COMPLEMENT)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .update_event(update_event), .ch1_capture_event(ch1_capture_event),
  .ctrl_update_event(ctrl_update_event), .break_event(break_event), .ch1_dma_req(ch1_dma_req)
);

// ---- test/test_tseg_top.sv ----
// test_tseg_top: self-checking bench for the timer software event block.
// assumes: tseg_top alone on an AHB-Lite bus mastered by this bench.
`timescale 1ns/1ps
module test_tseg_top;
  localparam logic [32:0] IGN = 33'h1_0000_0000;  // read not compared
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, update_event, ch1_capture_event;
  logic        ctrl_update_event, break_event, ch1_dma_req, irq;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic        rd_dp = 1'b0;
  logic [15:0] rnd = 16'h0040;
  logic [31:0] v, r;
  logic [7:0]  cv[5] = '{8'h10, 8'h00, 8'h30, 8'h14, 8'h02};
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;

  tseg_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .update_event(update_event),
    .ch1_capture_event(ch1_capture_event), .ctrl_update_event(ctrl_update_event),
    .break_event(break_event), .ch1_dma_req(ch1_dma_req), .irq(irq)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one single transfer, held until hready is sampled high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    if (a == tseg_pkg::EVTRIG_OFS) @(posedge hclk);  // trigger effects land
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // ************************************************************
  // clock, monitor, timeout
  // ************************************************************
  initial forever #50 hclk = ~hclk;
  // compare read data when a read data phase completes
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      if (!e[32]) chk("hrdata", hrdata, e[31:0]);
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(tseg_pkg::CH1VAL_OFS, 32'hffff);
    rd(tseg_pkg::STATUS_OFS, 33'h0);
    rd(tseg_pkg::EVTRIG_OFS, 33'h0);
    rd(tseg_pkg::CHMODE_OFS, 33'h0);
    rnd = lfsr(rnd);
    v = {16'h0, rnd & 16'hfffc};
    wr(tseg_pkg::CHMODE_OFS, v);
    rd(tseg_pkg::CHMODE_OFS, {1'b0, v});
    wr(tseg_pkg::CHEN_OFS, 32'h1);
    wr(tseg_pkg::CHMODE_OFS, v | 32'h1);
    rd(tseg_pkg::CHMODE_OFS, {1'b0, v});
    wr(tseg_pkg::CHEN_OFS, 32'h0);
    // output mode channel event, unmasked, dma on
    wr(tseg_pkg::IRQ_EN_OFS, 32'h82);
    wr(tseg_pkg::CTRL_OFS, 32'h100);
    wr(tseg_pkg::EVTRIG_OFS, 32'h2);
    wr(tseg_pkg::EVTRIG_OFS, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(tseg_pkg::STATUS_OFS, 33'h2);
    repeat (3) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0);
    // masked break
    wr(tseg_pkg::IRQ_EN_OFS, 32'h0);
    wr(tseg_pkg::EVTRIG_OFS, 32'h80);
    repeat (3) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(tseg_pkg::STATUS_OFS, 33'h80);
    // forced updates over count modes and update gating
    rnd = lfsr(rnd);
    r = {17'h0, rnd[14:0] | 15'h1};
    wr(tseg_pkg::RELOAD_OFS, r);
    for (int i = 0; i < 5; i++) begin
      wr(tseg_pkg::CTRL_OFS, {24'h0, cv[i]});
      wr(tseg_pkg::EVTRIG_OFS, 32'h1);
      rd(tseg_pkg::COUNT_OFS, {1'b0, (i == 0 || i >= 3) ? r : 32'h0});
      rd(tseg_pkg::STATUS_OFS, {32'h0, i < 3});
    end
    // input mode capture and over-capture
    wr(tseg_pkg::CTRL_OFS, 32'h110);
    wr(tseg_pkg::EVTRIG_OFS, 32'h1);
    wr(tseg_pkg::CHMODE_OFS, 32'h1);
    wr(tseg_pkg::EVTRIG_OFS, 32'h2);
    wr(tseg_pkg::EVTRIG_OFS, 32'h2);
    rd(tseg_pkg::CH1VAL_OFS, {1'b0, r});
    rd(tseg_pkg::STATUS_OFS, 33'h203);
    // control update with break, then reserved bits alone
    wr(tseg_pkg::EVTRIG_OFS, 32'ha0);
    rd(tseg_pkg::STATUS_OFS, 33'ha0);
    wr(tseg_pkg::EVTRIG_OFS, 32'hff5c);
    rd(tseg_pkg::STATUS_OFS, 33'h0);
    rd(8'h3c, 33'h0);
    @(posedge hclk);
    test_done();
  end
endmodule : test_tseg_top
